// [logic/aspc_pkg.sv]
`default_nettype none
package aspc_pkg;
	// ****************
	// Register map
	// ****************
	localparam logic [9:0] IDX_DATA = 10'h000;
	localparam logic [9:0] IDX_STAT = 10'h001;
	localparam logic [9:0] IDX_MASK = 10'h002;
	localparam logic [9:0] IDX_FMT = 10'h0a9;
	localparam int ST_RXD = 0;
	localparam int ST_TXD = 1;
	localparam int ST_RXX = 2;
	localparam int ST_TBX = 3;
	localparam int ST_REN = 4;
	localparam int ST_OVR = 5;
	localparam int ST_THRE = 6;
	localparam int ST_PERR = 7;
	localparam logic [7:0] W1C_MASK = 8'ha3;
	localparam int F_SBL = 0;
	localparam int F_XBE = 1;
	localparam int F_DL = 2;
	localparam int F_PE = 4;
	localparam int F_PT = 5;
	localparam int F_MCE = 7;
	localparam logic [7:0] FMT_RST = 8'h0c;
	localparam logic [7:0] MASK_RST = 8'h00;
	// ****************
	// Bit timing, in baud ticks minus one, and receive FIFO full count
	// ****************
	localparam logic [4:0] BIT_LAST = 5'h0f;
	localparam logic [4:0] MID_TICK = 5'h07;
	localparam logic [4:0] STOP2_LAST = 5'h1f;
	localparam logic [4:0] STOP15_LAST = 5'h17;
	localparam logic [1:0] FIFO_LAST = 2'h3;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_XBIT, TX_STOP} aspc_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} aspc_rx_st_t;
	function automatic logic [3:0] aspc_nbits(input logic [1:0] dl);
		return 4'h5 + {2'h0, dl};
	endfunction : aspc_nbits
	function automatic logic [7:0] aspc_dmask(input logic [1:0] dl);
		return 8'hff >> (2'h3 - dl);
	endfunction : aspc_dmask
	function automatic logic aspc_par(input logic [7:0] d, input logic [1:0] pt);
		case (pt)
			2'h0: return ~^d;
			2'h1: return ^d;
			2'h2: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : aspc_par
	function automatic logic [4:0] aspc_stop_last(input logic [7:0] f);
		if (!f[F_SBL]) return BIT_LAST;
		return (f[F_DL+:2] == 2'h0) ? STOP15_LAST : STOP2_LAST;
	endfunction : aspc_stop_last
endpackage : aspc_pkg
`default_nettype wire

// [logic/aspc_tx_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface aspc_tx_if;
	logic ld;
	logic [7:0] data;
	logic xbit;
	logic [7:0] fmt;
	logic hold_empty;
	logic done;
	modport tx (input ld, input data, input xbit, input fmt, output hold_empty, output done);
	modport ctl (output ld, output data, output xbit, output fmt, input hold_empty, input done);
endinterface : aspc_tx_if
`default_nettype wire

// [logic/aspc_tx.sv]
`timescale 1ns/1ps
`default_nettype none
module aspc_tx import aspc_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bit timing
	input wire logic baud_tick,
	// Control side
	aspc_tx_if.tx txp,
	// Line
	output logic serial_out_line
);
	aspc_tx_st_t st_r, st_nxt;
	logic [7:0] hold_r, hold_nxt, sh_r, sh_nxt, cfg_r, cfg_nxt;
	logic hfull_r, hfull_nxt, hx_r, hx_nxt, xb_r, xb_nxt;
	logic out_r, out_nxt, done_r, done_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic [3:0] nb;
	logic has_x, tick_end;

	assign nb = aspc_nbits(cfg_r[F_DL+:2]);
	assign has_x = cfg_r[F_PE] | cfg_r[F_XBE];
	assign tick_end = baud_tick && (cnt_r == ((st_r == TX_STOP) ? aspc_stop_last(cfg_r) : BIT_LAST));
	assign serial_out_line = out_r;
	assign txp.hold_empty = !hfull_r;
	assign txp.done = done_r;

	always_comb begin
		st_nxt = st_r;
		hold_nxt = hold_r;
		hfull_nxt = hfull_r;
		hx_nxt = hx_r;
		sh_nxt = sh_r;
		cfg_nxt = cfg_r;
		xb_nxt = xb_r;
		out_nxt = out_r;
		cnt_nxt = (baud_tick && !tick_end) ? cnt_r + 5'h01 : cnt_r;
		idx_nxt = idx_r;
		done_nxt = 1'b0;
		// [R2] load holding
		// A write into a full holding register is dropped, so the line never hangs
		if (txp.ld && !hfull_r) begin
			hold_nxt = txp.data;
			hx_nxt = txp.xbit;
			hfull_nxt = 1'b1;
		end
		case (st_r)
			TX_IDLE: begin
				// [R2] start when idle
				if (hfull_r) begin
					hfull_nxt = 1'b0;
					cfg_nxt = txp.fmt;
					sh_nxt = hold_r & aspc_dmask(txp.fmt[F_DL+:2]);
					// [R5] [R6] [R12] [R13] extra bit value
					xb_nxt = txp.fmt[F_PE] ?
						aspc_par(hold_r & aspc_dmask(txp.fmt[F_DL+:2]), txp.fmt[F_PT+:2]) : hx_r;
					// [R16] start bit low
					out_nxt = 1'b0;
					cnt_nxt = 5'h00;
					st_nxt = TX_START;
				end
			end
			TX_START: if (tick_end) begin
				cnt_nxt = 5'h00;
				idx_nxt = 3'h0;
				out_nxt = sh_r[0];
				st_nxt = TX_DATA;
			end
			TX_DATA: if (tick_end) begin
				cnt_nxt = 5'h00;
				// [R14] data length
				if ({1'b0, idx_r} == nb - 4'h1) begin
					out_nxt = has_x ? xb_r : 1'b1;
					done_nxt = !has_x;
					st_nxt = has_x ? TX_XBIT : TX_STOP;
				end else begin
					sh_nxt = sh_r >> 1;
					out_nxt = sh_r[1];
					idx_nxt = idx_r + 3'h1;
				end
			end
			TX_XBIT: if (tick_end) begin
				cnt_nxt = 5'h00;
				out_nxt = 1'b1;
				// [R3] done at stop start
				done_nxt = 1'b1;
				st_nxt = TX_STOP;
			end
			TX_STOP: begin
				// [R15] [R14] stop length
				if (tick_end) begin
					cnt_nxt = 5'h00;
					st_nxt = TX_IDLE;
				end
			end
			default: st_nxt = TX_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= TX_IDLE;
			hold_r <= 8'h00;
			hfull_r <= 1'b0;
			hx_r <= 1'b0;
			sh_r <= 8'h00;
			cfg_r <= FMT_RST;
			xb_r <= 1'b0;
			out_r <= 1'b1;
			cnt_r <= 5'h00;
			idx_r <= 3'h0;
			done_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			hold_r <= hold_nxt;
			hfull_r <= hfull_nxt;
			hx_r <= hx_nxt;
			sh_r <= sh_nxt;
			cfg_r <= cfg_nxt;
			xb_r <= xb_nxt;
			out_r <= out_nxt;
			cnt_r <= cnt_nxt;
			idx_r <= idx_nxt;
			done_r <= done_nxt;
		end
	end

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_done_stop; // [R3]
		txp.done |-> serial_out_line && st_r == TX_STOP && $past(st_r) != TX_STOP;
	endproperty
	a_done_stop: assert property (p_done_stop) else $error("done flag not at stop start");
	property p_xbit_val; // [R5]
		st_r == TX_XBIT && !cfg_r[F_PE] |-> serial_out_line == xb_r && cfg_r[F_XBE];
	endproperty
	a_xbit_val: assert property (p_xbit_val) else $error("extra bit slot wrong");
endmodule : aspc_tx
`default_nettype wire

// [logic/aspc_core.sv]
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [R1] Software: two nodes keep qualifier off; multi-drop sets qualifier and extra bit.
// [R2] Data write fills holding register, clears empty flag; sent when idle.
// [R3] Transmit done flag sets at stop-bit start and can interrupt.
// [R4] Software must not write while holding full; poll transmit done flag.
// [R5] Extra bit on, parity off: send written extra bit after data.
// [R6] Parity on: append computed parity; extra bit function unavailable.
// [R7] Receiver accepts frames only while receive enable is one; code checks it only at frame start, so a frame under way still completes.
// [R8] Byte pushed into three-entry FIFO only if space and stops high.
// [R9] Byte completing into full FIFO is dropped and sets overrun.
// [R10] Frame with a low stop bit is not stored.
// [R11] Receive flag needs stop high; with qualifier also extra bit high.
// [R12] Parity type: 00 odd, 01 even, 10 mark, 11 space.
// [R13] Parity enable switches both generation and checking.
// [R14] Length 5 to 8 bits; long stop is two, or 1.5 at five.
// [R15] Short stop setting gives exactly one stop-bit period.
// [R16] Low start, data LSB first, optional extra bit, high stops.
// [R17] Timing from external baud tick; receiver samples mid-bit.
module aspc_core import aspc_pkg::*; (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Bit timing, 16 ticks per bit
	input wire logic baud_tick,
	// Serial lines
	input wire logic serial_in_line,
	output logic serial_out_line,
	// Interrupt
	output logic irq
);
	aspc_tx_if txi();

	// ****************
	// Bus slave
	// ****************
	logic awr_r, awr_nxt, ard_r, ard_nxt;
	logic [9:0] aidx_r, aidx_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic take;
	logic [7:0] stat_view;

	// Reads take one wait state so read data leaves a flop
	assign take = hsel && htrans[1] && hready;
	assign hreadyout = !ard_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	function automatic logic hit(input logic [9:0] a, input logic [9:0] idx);
		return a == idx;
	endfunction : hit

	// ****************
	// Register state and receive FIFO
	// ****************
	logic [7:0] fmt_r, fmt_nxt, mask_r, mask_nxt, flg_r, flg_nxt, ev, clr;
	logic ren_r, ren_nxt, tbx_r, tbx_nxt, rxx_r, rxx_nxt;
	logic [7:0] mem_r [3];
	logic [7:0] mem_nxt [3];
	logic [1:0] wp_r, wp_nxt, rp_r, rp_nxt, fcnt_r, fcnt_nxt;
	logic push, pop, full, wr_stat;

	// ****************
	// Receiver
	// ****************
	aspc_rx_st_t rst_r, rst_nxt;
	logic rxs1_r, rxs2_r;
	logic [4:0] rcnt_r, rcnt_nxt;
	logic [3:0] ridx_r, ridx_nxt, rnb, rtot;
	logic [8:0] rsh_r, rsh_nxt;
	logic [7:0] rcfg_r, rcfg_nxt, rx_data;
	logic rstp_r, rstp_nxt, rok_r, rok_nxt, rx_two, rx_end, rx_good, rx_xbit, perr;

	always_comb begin
		awr_nxt = take && hwrite;
		ard_nxt = take && !hwrite;
		aidx_nxt = take ? haddr[11:2] : aidx_r;
		hrdata_nxt = hrdata_r;
		if (ard_r) begin
			case (aidx_r)
				IDX_DATA: hrdata_nxt = {24'h0000_00, mem_r[rp_r]};
				IDX_STAT: hrdata_nxt = {24'h0000_00, stat_view};
				IDX_MASK: hrdata_nxt = {24'h0000_00, mask_r};
				IDX_FMT: hrdata_nxt = {24'h0000_00, fmt_r};
				default: hrdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			awr_r <= 1'b0;
			ard_r <= 1'b0;
			aidx_r <= 10'h000;
			hrdata_r <= 32'h0000_0000;
		end else begin
			awr_r <= awr_nxt;
			ard_r <= ard_nxt;
			aidx_r <= aidx_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	always_comb begin
		stat_view = flg_r;
		stat_view[ST_RXX] = rxx_r;
		stat_view[ST_TBX] = tbx_r;
		stat_view[ST_REN] = ren_r;
		stat_view[ST_THRE] = txi.hold_empty;
	end

	// [R2] data write loads transmitter
	assign txi.ld = awr_r && hit(aidx_r, IDX_DATA);
	assign txi.data = hwdata[7:0];
	assign txi.xbit = tbx_r;
	assign txi.fmt = fmt_r;

	aspc_tx u_tx (
		.hclk(hclk),
		.hresetn(hresetn),
		.baud_tick(baud_tick),
		.txp(txi.tx),
		.serial_out_line(serial_out_line)
	);

	assign wr_stat = awr_r && hit(aidx_r, IDX_STAT);
	assign full = fcnt_r == FIFO_LAST;
	assign pop = ard_r && hit(aidx_r, IDX_DATA) && fcnt_r != 2'h0;
	// [R8] [R10] push only good frames with space
	assign push = rx_end && rx_good && !full;
	assign irq = |(flg_r & mask_r);

	always_comb begin
		fmt_nxt = fmt_r;
		mask_nxt = mask_r;
		ren_nxt = ren_r;
		tbx_nxt = tbx_r;
		rxx_nxt = rxx_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		fcnt_nxt = fcnt_r;
		mem_nxt = mem_r;
		ev = 8'h00;
		clr = wr_stat ? hwdata[7:0] : 8'h00;
		if (awr_r && hit(aidx_r, IDX_FMT)) fmt_nxt = hwdata[7:0];
		if (awr_r && hit(aidx_r, IDX_MASK)) mask_nxt = hwdata[7:0] & W1C_MASK;
		if (wr_stat) begin
			ren_nxt = hwdata[ST_REN];
			tbx_nxt = hwdata[ST_TBX];
		end
		for (int i = 0; i < 3; i++) begin
			if (push && wp_r == i[1:0]) mem_nxt[i] = rx_data;
		end
		if (push) begin
			wp_nxt = (wp_r == 2'h2) ? 2'h0 : wp_r + 2'h1;
			rxx_nxt = rx_xbit;
		end
		if (pop) rp_nxt = (rp_r == 2'h2) ? 2'h0 : rp_r + 2'h1;
		fcnt_nxt = fcnt_r + {1'b0, push} - {1'b0, pop};
		// [R11] qualified receive flag
		ev[ST_RXD] = push && (!rcfg_r[F_MCE] || rx_xbit);
		// [R3] transmit done event
		ev[ST_TXD] = txi.done;
		// [R9] overrun when full
		ev[ST_OVR] = rx_end && full;
		ev[ST_PERR] = perr;
		// A flag set in the same cycle as its clear stays set
		flg_nxt = ((flg_r & ~clr) | ev) & W1C_MASK;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fmt_r <= FMT_RST;
			mask_r <= MASK_RST;
			flg_r <= 8'h00;
			ren_r <= 1'b0;
			tbx_r <= 1'b0;
			rxx_r <= 1'b0;
			wp_r <= 2'h0;
			rp_r <= 2'h0;
			fcnt_r <= 2'h0;
			mem_r <= '{default: 8'h00};
		end else begin
			fmt_r <= fmt_nxt;
			mask_r <= mask_nxt;
			flg_r <= flg_nxt;
			ren_r <= ren_nxt;
			tbx_r <= tbx_nxt;
			rxx_r <= rxx_nxt;
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			fcnt_r <= fcnt_nxt;
			mem_r <= mem_nxt;
		end
	end

	assign rnb = aspc_nbits(rcfg_r[F_DL+:2]);
	assign rtot = rnb + {3'h0, rcfg_r[F_PE] | rcfg_r[F_XBE]};
	assign rx_two = rcfg_r[F_SBL] && rcfg_r[F_DL+:2] != 2'h0;
	assign rx_data = rsh_r[7:0] & aspc_dmask(rcfg_r[F_DL+:2]);
	assign rx_xbit = rsh_r[rnb];
	assign rx_good = rok_r && rxs2_r;
	// [R13] [R12] parity check
	assign perr = rx_end && rx_good && rcfg_r[F_PE] &&
		(rx_xbit != aspc_par(rx_data, rcfg_r[F_PT+:2]));

	always_comb begin
		rst_nxt = rst_r;
		rcnt_nxt = (baud_tick && rcnt_r != BIT_LAST) ? rcnt_r + 5'h01 : rcnt_r;
		ridx_nxt = ridx_r;
		rsh_nxt = rsh_r;
		rcfg_nxt = rcfg_r;
		rstp_nxt = rstp_r;
		rok_nxt = rok_r;
		rx_end = 1'b0;
		case (rst_r)
			RX_IDLE: begin
				rcnt_nxt = 5'h00;
				// [R7] only when enabled
				if (ren_r && !rxs2_r) begin
					rcfg_nxt = fmt_r;
					rsh_nxt = 9'h000;
					rst_nxt = RX_START;
				end
			end
			// [R17] [R16] confirm start at mid-bit
			RX_START: if (baud_tick && rcnt_r == MID_TICK) begin
				rcnt_nxt = 5'h00;
				ridx_nxt = 4'h0;
				rst_nxt = rxs2_r ? RX_IDLE : RX_DATA;
			end
			RX_DATA: if (baud_tick && rcnt_r == BIT_LAST) begin
				rcnt_nxt = 5'h00;
				rsh_nxt[ridx_r] = rxs2_r;
				ridx_nxt = ridx_r + 4'h1;
				// [R14] data plus extra bit count
				if (ridx_r == rtot - 4'h1) begin
					rstp_nxt = 1'b0;
					rok_nxt = 1'b1;
					rst_nxt = RX_STOP;
				end
			end
			RX_STOP: if (baud_tick && rcnt_r == BIT_LAST) begin
				rcnt_nxt = 5'h00;
				rok_nxt = rx_good;
				// [R10] every stop sampled
				if (rstp_r == rx_two) begin
					rx_end = 1'b1;
					rst_nxt = RX_IDLE;
				end else begin
					rstp_nxt = 1'b1;
				end
			end
			default: rst_nxt = RX_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxs1_r <= 1'b1;
			rxs2_r <= 1'b1;
			rst_r <= RX_IDLE;
			rcnt_r <= 5'h00;
			ridx_r <= 4'h0;
			rsh_r <= 9'h000;
			rcfg_r <= FMT_RST;
			rstp_r <= 1'b0;
			rok_r <= 1'b0;
		end else begin
			rxs1_r <= serial_in_line;
			rxs2_r <= rxs1_r;
			rst_r <= rst_nxt;
			rcnt_r <= rcnt_nxt;
			ridx_r <= ridx_nxt;
			rsh_r <= rsh_nxt;
			rcfg_r <= rcfg_nxt;
			rstp_r <= rstp_nxt;
			rok_r <= rok_nxt;
		end
	end

	// ****************
	// Checks
	// ****************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_load_empty;
		txi.ld ##0 txi.hold_empty;
	endsequence
	property p_load_clears; // [R2]
		s_load_empty |=> !txi.hold_empty;
	endproperty
	a_load_clears: assert property (p_load_clears) else $error("holding flag not cleared");
	property p_rx_gate; // [R7]
		rst_r == RX_IDLE && !ren_r |=> rst_r == RX_IDLE;
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("receiver started while disabled");
	property p_push_cnt; // [R8]
		push && !pop |=> fcnt_r == $past(fcnt_r) + 2'h1 && mem_r[$past(wp_r)] == $past(rx_data);
	endproperty
	a_push_cnt: assert property (p_push_cnt) else $error("FIFO push lost");
	sequence s_end_full;
		rx_end && full;
	endsequence
	property p_overrun; // [R9]
		s_end_full |-> !push ##1 flg_r[ST_OVR];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");
	property p_bad_stop; // [R10]
		rx_end && !rx_good |-> !push ##1 fcnt_r == $past(fcnt_r) - {1'b0, $past(pop)};
	endproperty
	a_bad_stop: assert property (p_bad_stop) else $error("bad stop frame stored");
	property p_rx_flag; // [R11]
		$rose(flg_r[ST_RXD]) |-> $past(push && (!rcfg_r[F_MCE] || rx_xbit));
	endproperty
	a_rx_flag: assert property (p_rx_flag) else $error("receive flag without cause");
	property p_tx_irq; // [R3]
		txi.done && mask_r[ST_TXD] |=> flg_r[ST_TXD] && irq;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("transmit interrupt missing");
	property p_start_mid; // [R17]
		rst_r == RX_START && baud_tick && rcnt_r == MID_TICK && !rxs2_r |=> rst_r == RX_DATA;
	endproperty
	a_start_mid: assert property (p_start_mid) else $error("start bit not taken at mid");
endmodule : aspc_core
`default_nettype wire

// [bench/aspc_remote.sv]
`timescale 1ns/1ps
`default_nettype none
module aspc_remote (
	// Clock and bit timing
	input wire logic hclk,
	input wire logic baud_tick,
	// Lines
	input wire logic line_in,
	output logic line_out
);
	// ****************
	// Frame driver
	// ****************
	initial line_out = 1'b1;
	task automatic bit_out(input logic v);
		line_out <= v;
		repeat (16) @(posedge hclk iff baud_tick);
	endtask : bit_out
	// low start, LSB first, stop bit at the level given by stp
	task automatic send(input logic [7:0] d, input int nb, input bit xen, input logic xb,
		input logic stp);
		bit_out(1'b0);
		for (int i = 0; i < nb; i++) bit_out(d[i]);
		if (xen) bit_out(xb);
		bit_out(stp);
		// One idle bit so the receiver is at rest before the next frame
		bit_out(1'b1);
	endtask : send
	// ****************
	// Frame monitor
	// ****************
	// mid-bit sampling, LSB first
	task automatic recv(input int nb, input bit xen, output logic [7:0] d, output logic xb,
		output logic stp, output int hi);
		d = 8'h00;
		xb = 1'b0;
		hi = 0;
		wait (line_in === 1'b0);
		repeat (8) @(posedge hclk iff baud_tick);
		for (int i = 0; i < nb; i++) begin
			repeat (16) @(posedge hclk iff baud_tick);
			d[i] = line_in;
		end
		if (xen) begin
			repeat (16) @(posedge hclk iff baud_tick);
			xb = line_in;
		end
		repeat (16) @(posedge hclk iff baud_tick);
		stp = line_in;
		// Ticks of high line until the next start, capped for a lone frame
		while (line_in === 1'b1 && hi < 40) begin
			@(posedge hclk iff baud_tick);
			hi++;
		end
	endtask : recv
endmodule : aspc_remote
`default_nettype wire

// [bench/async_serial_port_core_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module async_serial_port_core_bench import aspc_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, baud_tick, irq;
	logic serial_in_line, serial_out_line;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata;
	int num_errors, n_checks;
	localparam logic [31:0] A_DATA = {20'h0_0000, IDX_DATA, 2'b00};
	localparam logic [31:0] A_STAT = {20'h0_0000, IDX_STAT, 2'b00};
	localparam logic [31:0] A_MASK = {20'h0_0000, IDX_MASK, 2'b00};
	localparam logic [31:0] A_FMT = {20'h0_0000, IDX_FMT, 2'b00};
	localparam logic [31:0] A_NONE = 32'h0000_0100;
	aspc_core aspc_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .baud_tick(baud_tick),
		.serial_in_line(serial_in_line), .serial_out_line(serial_out_line), .irq(irq));
	aspc_remote aspc_remote_i (.hclk(hclk), .baud_tick(baud_tick), .line_in(serial_out_line),
		.line_out(serial_in_line));
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// Two clocks per tick keeps frames short
	always @(posedge hclk) baud_tick <= ~baud_tick;
	// ****************
	// Bus and compare tasks
	// ****************
	task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb_xfer
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] x;
		ahb_xfer(a, 1'b1, {24'h00_0000, d}, x);
	endtask : wr
	task automatic check_eq(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask : check_eq
	task automatic check_rng(input int g, input int lo, input int hi, input string m);
		n_checks++;
		if (g < lo || g > hi) begin
			num_errors++;
			$display("[FAIL] %0t %s got %0d", $time, m, g);
		end
	endtask : check_rng
	task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string m);
		logic [31:0] x;
		ahb_xfer(a, 1'b0, 32'h0000_0000, x);
		check_eq(x, e, m);
	endtask : rd_chk
	// ****************
	// Scenarios
	// ****************
	task automatic tx_case(input logic [7:0] f, input logic [7:0] d, input logic tbx,
		input logic mi);
		logic [7:0] got, dm;
		logic gx, gs, ex;
		int hi;
		logic [31:0] st;
		dm = d & (8'hff >> (3 - f[3:2]));
		case (f[6:5])
			2'h0: ex = ~^dm;
			2'h1: ex = ^dm;
			2'h2: ex = 1'b1;
			default: ex = 1'b0;
		endcase
		if (!f[4]) ex = tbx;
		wr(A_FMT, f);
		wr(A_STAT, {4'ha, tbx, 3'h3});
		fork
			aspc_remote_i.recv(f[3:2] + 5, f[4] | f[1], got, gx, gs, hi);
			wr(A_DATA, d);
		join
		check_eq(got, dm, "tx data");
		if (f[4] | f[1]) check_eq(gx, ex, "tx extra");
		check_eq(gs, 1'b1, "tx stop");
		ahb_xfer(A_STAT, 1'b0, 32'h0000_0000, st);
		check_eq(st[1], 1'b1, "tx done");
		check_eq(irq, mi, "irq set");
		wr(A_STAT, 8'h02);
		repeat (2) @(posedge hclk);
		check_eq(irq, 1'b0, "irq clear");
	endtask : tx_case
	task automatic b2b(input logic [7:0] f, input int s);
		logic [7:0] g;
		logic gx, gs;
		int hi;
		logic [31:0] st;
		wr(A_FMT, f);
		fork
			aspc_remote_i.recv(f[3:2] + 5, 1'b0, g, gx, gs, hi);
			begin
				wr(A_DATA, 8'h81);
				// Second write only once the shifter has taken the first byte
				repeat (4) @(posedge hclk);
				wr(A_DATA, 8'h7e);
				ahb_xfer(A_STAT, 1'b0, 32'h0000_0000, st);
			end
		join
		check_eq(st[6], 1'b0, "holding full");
		check_rng(hi, s - 10, s - 6, "stop length");
		aspc_remote_i.recv(f[3:2] + 5, 1'b0, g, gx, gs, hi);
		check_eq(g, 8'h7e & (8'hff >> (3 - f[3:2])), "second byte");
	endtask : b2b
	task automatic rx_chk(input logic [7:0] f, input logic [7:0] d, input logic xb,
		input logic stp, input logic ren, input logic [31:0] e);
		wr(A_FMT, f);
		wr(A_STAT, {3'h5, ren, 4'h3});
		aspc_remote_i.send(d, f[3:2] + 5, f[4] | f[1], xb, stp);
		rd_chk(A_STAT, e, "rx status");
	endtask : rx_chk
	task automatic final_report;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : final_report
	initial begin
		#300_000;
		num_errors++;
		final_report();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		baud_tick = 1'b0;
		num_errors = 0;
		n_checks = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd_chk(A_FMT, {24'h00_0000, FMT_RST}, "fmt reset");
		rd_chk(A_MASK, 32'h0000_0000, "mask reset");
		rd_chk(A_STAT, 32'h0000_0040, "status reset");
		check_eq(hresp, 1'b0, "okay response");
		wr(A_FMT, 8'hff);
		rd_chk(A_FMT, 32'h0000_00ff, "fmt rw");
		wr(A_MASK, 8'hff);
		rd_chk(A_MASK, {24'h00_0000, W1C_MASK}, "mask bits");
		wr(A_NONE, 8'h5a);
		rd_chk(A_NONE, 32'h0000_0000, "unmapped");
		wr(A_MASK, 8'h02);
		tx_case(8'h0c, 8'h96, 1'b0, 1'b1);
		wr(A_MASK, 8'h00);
		tx_case(8'h0e, 8'h3c, 1'b1, 1'b0);
		tx_case(8'h0e, 8'h3d, 1'b0, 1'b0);
		for (int k = 0; k < 4; k++) begin
			tx_case({1'b0, k[1:0], 1'b1, k[1:0], 2'h0}, 8'h5a + 8'h33 * k, 1'b1, 1'b0);
		end
		b2b(8'h0c, 16);
		b2b(8'h0d, 32);
		b2b(8'h01, 24);
		rx_chk(8'h0c, 8'h11, 1'b0, 1'b1, 1'b0, 32'h0000_0040);
		rx_chk(8'h0c, 8'h22, 1'b0, 1'b0, 1'b1, 32'h0000_0050);
		rx_chk(8'h1c, 8'h01, 1'b1, 1'b1, 1'b1, 32'h0000_00d5);
		rd_chk(A_DATA, 32'h0000_0001, "parity byte kept");
		rx_chk(8'h8e, 8'h33, 1'b0, 1'b1, 1'b1, 32'h0000_0050);
		rx_chk(8'h8e, 8'h44, 1'b1, 1'b1, 1'b1, 32'h0000_0055);
		rd_chk(A_DATA, 32'h0000_0033, "addr frame 0");
		rd_chk(A_DATA, 32'h0000_0044, "addr frame 1");
		wr(A_FMT, 8'h0c);
		wr(A_STAT, 8'hb3);
		for (int k = 0; k < 4; k++) aspc_remote_i.send(8'h60 + k[7:0], 8, 1'b0, 1'b0, 1'b1);
		rd_chk(A_STAT, 32'h0000_0071, "overrun");
		for (int k = 0; k < 3; k++) rd_chk(A_DATA, 32'h60 + k, "fifo");
		final_report();
	end
endmodule : async_serial_port_core_bench
`default_nettype wire
